//--- logic/port_power_select.v
`timescale 1ns/1ps
`include "root_hub_desc_defines.vh"

module port_power_select (
    input wire no_power_switching,
    input wire power_switching_mode,
    input wire [15:0] port_power_control_mask,
    input wire [15:0] port_power_set,
    input wire [15:0] port_power_clear,
    input wire global_power_set,
    input wire global_power_clear,
    input wire [15:0] port_power,
    output reg [15:0] next_port_power
);
    integer i;
    always @* begin
        next_port_power = port_power;
        for (i = 0; i < 16; i = i + 1) begin
            if (no_power_switching) begin
                next_port_power[i] = 1'b1;
            end else if (power_switching_mode && port_power_control_mask[i]) begin
                if (port_power_set[i])
                    next_port_power[i] = 1'b1;
                else if (port_power_clear[i])
                    next_port_power[i] = 1'b0;
            end else begin
                if (global_power_set)
                    next_port_power[i] = 1'b1;
                else if (global_power_clear)
                    next_port_power[i] = 1'b0;
            end
        end
    end
endmodule

//--- logic/root_hub_desc_defines.vh
`ifndef ROOT_HUB_DESC_DEFINES_VH
`define ROOT_HUB_DESC_DEFINES_VH

// ----------------------------------------
// register offset
// ----------------------------------------
`define RHDA_OFFSET 8'h48

// ----------------------------------------
// field positions
// ----------------------------------------
`define RHDA_PGD_HI 31
`define RHDA_PGD_LO 24
`define RHDA_NO_OC_BIT 12
`define RHDA_OC_MODE_BIT 11
`define RHDA_TYPE_BIT 10
`define RHDA_NO_SW_BIT 9
`define RHDA_SW_MODE_BIT 8
`define RHDA_COUNT_HI 7
`define RHDA_COUNT_LO 0

// ----------------------------------------
// reset values and port count range
// ----------------------------------------
`define RHDA_PGD_RESET 8'hFF
`define RHDA_NO_OC_RESET 1'b0
`define RHDA_NO_SW_RESET 1'b0
`define RHDA_SW_MODE_RESET 1'b1
`define RHDA_COUNT_RESET 8'h01
`define RHDA_COUNT_MIN 8'h01
`define RHDA_COUNT_MAX 8'h0F

// ----------------------------------------
// timing
// ----------------------------------------
`define PGD_UNIT_MS 2
`define CLK_MHZ 250
`define PGD_UNIT_CYCLES (`PGD_UNIT_MS * 1000 * `CLK_MHZ)

`endif

//--- logic/root_hub_description_first.v
`timescale 1ns/1ps
`include "root_hub_desc_defines.vh"

module root_hub_description_first (
    input wire clk_sys,
    input wire rst,
    input wire clk_en,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [3:0] reg_be,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata,
    output reg reg_hit,
    input wire [15:0] port_power_control_mask,
    input wire [15:0] port_power_set,
    input wire [15:0] port_power_clear,
    input wire global_power_set,
    input wire global_power_clear,
    input wire [15:0] port_overcurrent,
    output reg [15:0] port_power,
    output reg [15:0] port_overcurrent_status,
    output reg global_overcurrent_status,
    output reg power_good_pulse,
    output reg [7:0] downstream_port_count
);
    // ----------------------------------------
    // register fields
    // ----------------------------------------
    reg [7:0] power_good_delay;
    reg no_overcurrent_protect;
    reg overcurrent_report_mode;
    reg no_power_switching;
    reg power_switching_mode;
    reg [7:0] port_count_field;
    reg [15:0] prev_port_power;
    reg [7:0] pgd_units;
    reg [31:0] pgd_cycles;
    reg pgd_busy;
    wire [15:0] next_port_power;
    wire sel;
    wire [31:0] read_value;
    wire wr_hit;
    wire rd_hit;
    wire power_rise;
    // widened on purpose so the compare against the 32-bit counter is exact
    localparam [31:0] unit_last = `PGD_UNIT_CYCLES - 1;

    // clamp keeps the count inside the legal window
    function [7:0] clamp_ports;
        input [7:0] v;
        begin
            if (v < `RHDA_COUNT_MIN)
                clamp_ports = `RHDA_COUNT_MIN;
            else if (v > `RHDA_COUNT_MAX)
                clamp_ports = `RHDA_COUNT_MAX;
            else
                clamp_ports = v;
        end
    endfunction

    assign sel = (reg_addr == `RHDA_OFFSET);
    // strobes qualified by the one decoded offset
    assign wr_hit = sel && reg_wr;
    assign rd_hit = sel && reg_rd;
    // any port switching on restarts the wait; the last one powered sets the deadline
    assign power_rise = |(port_power & ~prev_port_power);

    assign read_value = {power_good_delay, 11'h000, no_overcurrent_protect,
        overcurrent_report_mode, 1'b0, no_power_switching, power_switching_mode,
        port_count_field};

    // ----------------------------------------
    // bus answer
    // ----------------------------------------
    // misses answer zero so that several banks can be ored onto one read bus
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
            reg_hit <= 1'b0;
        end else if (clk_en) begin
            reg_hit <= wr_hit || rd_hit;
            reg_rdata <= rd_hit ? read_value : 32'h00000000;
        end
    end

    // ----------------------------------------
    // field storage
    // ----------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            power_good_delay <= `RHDA_PGD_RESET;
            no_overcurrent_protect <= `RHDA_NO_OC_RESET;
            overcurrent_report_mode <= `RHDA_SW_MODE_RESET;
            no_power_switching <= `RHDA_NO_SW_RESET;
            power_switching_mode <= `RHDA_SW_MODE_RESET;
            port_count_field <= `RHDA_COUNT_RESET;
        end else if (clk_en) begin
            if (wr_hit) begin
                if (reg_be[3])
                    power_good_delay <= reg_wdata[`RHDA_PGD_HI:`RHDA_PGD_LO];
                if (reg_be[1]) begin
                    no_overcurrent_protect <= reg_wdata[`RHDA_NO_OC_BIT];
                    overcurrent_report_mode <= reg_wdata[`RHDA_OC_MODE_BIT];
                    no_power_switching <= reg_wdata[`RHDA_NO_SW_BIT];
                    power_switching_mode <= reg_wdata[`RHDA_SW_MODE_BIT];
                end
            end
        end
    end

    // ----------------------------------------
    // port power
    // ----------------------------------------
    // switching scheme applied
    port_power_select u_select (
        .no_power_switching(no_power_switching),
        .power_switching_mode(power_switching_mode),
        .port_power_control_mask(port_power_control_mask),
        .port_power_set(port_power_set),
        .port_power_clear(port_power_clear),
        .global_power_set(global_power_set),
        .global_power_clear(global_power_clear),
        .port_power(port_power),
        .next_port_power(next_port_power)
    );

    // ----------------------------------------
    // port power and port count
    // ----------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            port_power <= 16'h0000;
            prev_port_power <= 16'h0000;
            downstream_port_count <= `RHDA_COUNT_RESET;
        end else if (clk_en) begin
            port_power <= next_port_power;
            prev_port_power <= port_power;
            // count held legal
            // only the reported count is clamped; software reads the raw field
            downstream_port_count <= clamp_ports(port_count_field);
        end
    end

    // ----------------------------------------
    // overcurrent reporting
    // ----------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            port_overcurrent_status <= 16'h0000;
            global_overcurrent_status <= 1'b0;
        end else if (clk_en) begin
            if (no_overcurrent_protect) begin
                port_overcurrent_status <= 16'h0000;
                global_overcurrent_status <= 1'b0;
            end else if (overcurrent_report_mode) begin
                port_overcurrent_status <= port_overcurrent;
                global_overcurrent_status <= 1'b0;
            end else begin
                port_overcurrent_status <= 16'h0000;
                global_overcurrent_status <= |port_overcurrent;
            end
        end
    end

    // ----------------------------------------
    // power-good timer
    // ----------------------------------------
    // the pulse marks the end of the wait; software still owns the wait itself
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            power_good_pulse <= 1'b0;
            pgd_units <= 8'h00;
            pgd_cycles <= 32'h00000000;
            pgd_busy <= 1'b0;
        end else if (clk_en) begin
            power_good_pulse <= 1'b0;
            // delay counted in 2 ms units
            if (power_rise) begin
                pgd_busy <= 1'b1;
                pgd_units <= power_good_delay;
                pgd_cycles <= 32'h00000000;
            end else if (pgd_busy) begin
                if (pgd_units == 8'h00) begin
                    pgd_busy <= 1'b0;
                    power_good_pulse <= 1'b1;
                end else if (pgd_cycles == unit_last) begin
                    pgd_cycles <= 32'h00000000;
                    pgd_units <= pgd_units - 8'h01;
                end else begin
                    pgd_cycles <= pgd_cycles + 32'h00000001;
                end
            end
        end
    end
endmodule

//--- sim/root_hub_desc_monitor.sv
`timescale 1ns/1ps
module root_hub_desc_monitor (
    input wire clk_sys,
    input wire rst,
    input wire clk_en,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire reg_hit,
    input wire [15:0] port_overcurrent_status,
    input wire global_overcurrent_status,
    input wire power_good_pulse,
    input wire [7:0] downstream_port_count
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_type_reads_zero: assert property (clk_en && reg_rd |=> !reg_rdata[10])
        else $error("device type bit read as one");
    a_reserved_zero: assert property (clk_en && reg_rd
        |=> reg_rdata[23:13] == 11'h000)
        else $error("reserved bits read nonzero");
    a_count_in_range: assert property (downstream_port_count >= 8'h01
        && downstream_port_count <= 8'h0F)
        else $error("port count out of range");
    a_hit_on_match: assert property (clk_en && (reg_rd || reg_wr) && reg_addr == 8'h48
        |=> reg_hit)
        else $error("access at register offset not acknowledged");
    a_miss_quiet: assert property (clk_en && reg_rd && reg_addr != 8'h48
        |=> !reg_hit && reg_rdata == 32'h00000000)
        else $error("unmapped read answered");
    a_oc_one_mode: assert property (!(global_overcurrent_status && |port_overcurrent_status))
        else $error("both overcurrent reporting modes active");
    a_oc_collective: assert property (reg_hit && $past(reg_rd) && reg_rdata[12:11] == 2'b00
        |=> port_overcurrent_status == 16'h0000)
        else $error("per-port status in collective mode");
    a_no_protect_quiet: assert property (reg_hit && $past(reg_rd) && reg_rdata[12]
        |=> !global_overcurrent_status && port_overcurrent_status == 16'h0000)
        else $error("overcurrent reported without protection");
    a_pgood_single: assert property (power_good_pulse |=> !power_good_pulse)
        else $error("power good pulse longer than one cycle");
endmodule
bind root_hub_description_first root_hub_desc_monitor u_root_hub_desc_monitor (.*);

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    reg clk_sys = 1'b0;
    reg rst = 1'b1;
    reg [7:0] reg_addr = 8'h48;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [3:0] reg_be = 4'hF;
    reg [31:0] reg_wdata = 32'h0;
    reg [15:0] mask = 16'h0, pset = 16'h0, pclr = 16'h0, poc = 16'h0;
    reg gset = 1'b0, gclr = 1'b0;
    reg clk_en = 1'b1;
    wire [31:0] reg_rdata;
    wire reg_hit, goc, power_good_pulse;
    wire [15:0] port_power, poc_stat;
    wire [7:0] downstream_port_count;
    integer bad_count = 0, n_tests = 0;
    always #2 clk_sys = ~clk_sys;
    root_hub_description_first u_root_hub_description_first (.clk_sys(clk_sys), .rst(rst),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_be(reg_be),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .port_power_control_mask(mask), .port_power_set(pset), .port_power_clear(pclr),
        .global_power_set(gset), .global_power_clear(gclr), .port_overcurrent(poc),
        .port_power(port_power), .port_overcurrent_status(poc_stat),
        .global_overcurrent_status(goc), .power_good_pulse(power_good_pulse),
        .downstream_port_count(downstream_port_count));
    task check(input [63:0] name, input [31:0] seen, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("mismatch %0s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", n_tests, bad_count);
            if (bad_count == 0 && n_tests > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task wr(input [3:0] be, input [31:0] d);
        begin
            @(negedge clk_sys);
            reg_addr = 8'h48;
            reg_be = be;
            reg_wdata = d;
            reg_wr = 1'b1;
            @(negedge clk_sys);
            reg_wr = 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [31:0] exp);
        begin
            @(negedge clk_sys);
            reg_addr = a;
            reg_rd = 1'b1;
            @(negedge clk_sys);
            reg_rd = 1'b0;
            check("rdata", reg_rdata, exp);
            check("hit", {31'h0, reg_hit}, {31'h0, a == 8'h48});
        end
    endtask
    // commands are single-cycle pulses; only ports 1 and 2 are judged
    task cmd(input [15:0] s, input [15:0] c, input gs, input gc, input [15:0] exp);
        begin
            @(negedge clk_sys);
            pset = s;
            pclr = c;
            gset = gs;
            gclr = gc;
            @(negedge clk_sys);
            {pset, pclr, gset, gclr} = 34'h0;
            @(negedge clk_sys);
            check("power", {16'h0000, port_power & 16'h0006}, {16'h0000, exp});
        end
    endtask
    // the delay byte holds 8'h12 here, and the port count reads 1
    task oc(input [31:0] d, input g, input [15:0] p);
        begin
            wr(4'h2, d);
            repeat (2) @(negedge clk_sys);
            check("oc_glob", {31'h0, goc}, {31'h0, g});
            check("oc_port", {16'h0000, poc_stat}, {16'h0000, p});
            rd(8'h48, {16'h1200, d[15:0] | 16'h0001});
        end
    endtask
    task t_reset;
        begin
            rd(8'h48, 32'hFF000901);
            check("count", {24'h0, downstream_port_count}, 32'h1);
        end
    endtask
    task t_fields;
        begin
            // reserved bits are always written as zero
            wr(4'hF, 32'hFF001FFF);
            rd(8'h48, 32'hFF001B01);
            wr(4'hF, 32'h12000A00);
            rd(8'h48, 32'h12000A01);
            wr(4'h2, 32'hAB001000);
            rd(8'h48, 32'h12001001);
            // a write while the clock enable is low must leave every field alone
            clk_en = 1'b0;
            wr(4'hF, 32'h00000000);
            clk_en = 1'b1;
            rd(8'h48, 32'h12001001);
            rd(8'h4C, 32'h0);
        end
    endtask
    task t_power;
        begin
            // ports were left powered by the always-powered setting above
            cmd(16'h0, 16'h0, 1'b0, 1'b1, 16'h0000);
            mask = 16'h0002;
            wr(4'h2, 32'h100);
            cmd(16'h0, 16'h0, 1'b1, 1'b0, 16'h0004);
            cmd(16'h2, 16'h0, 1'b0, 1'b0, 16'h0006);
            cmd(16'h0, 16'h4, 1'b0, 1'b0, 16'h0006);
            cmd(16'h0, 16'h0, 1'b0, 1'b1, 16'h0002);
            cmd(16'h0, 16'h2, 1'b0, 1'b0, 16'h0000);
            wr(4'h2, 32'h0);
            cmd(16'h0, 16'h0, 1'b1, 1'b0, 16'h0006);
            cmd(16'h0, 16'h0, 1'b0, 1'b1, 16'h0000);
            wr(4'h2, 32'h200);
            cmd(16'h0, 16'h0, 1'b0, 1'b0, 16'h0006);
        end
    endtask
    task t_overcurrent;
        begin
            poc = 16'h0004;
            oc(32'h0000, 1'b1, 16'h0000);
            oc(32'h0800, 1'b0, 16'h0004);
            oc(32'h1800, 1'b0, 16'h0000);
        end
    endtask
    // a zero delay byte: the pulse follows the power rise by two cycles
    task t_power_good;
        begin
            wr(4'hF, 32'h00000000);
            cmd(16'h0, 16'h0, 1'b0, 1'b1, 16'h0000);
            cmd(16'h0, 16'h0, 1'b1, 1'b0, 16'h0006);
            // no port is touched before power good shows
            @(negedge clk_sys);
            check("pgood", {31'h0, power_good_pulse}, 32'h1);
            @(negedge clk_sys);
            check("pg_end", {31'h0, power_good_pulse}, 32'h0);
        end
    endtask
    initial begin
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        t_reset;
        t_fields;
        t_power;
        t_overcurrent;
        t_power_good;
        stop_test;
    end
    // whole sequence needs about 90 cycles
    initial begin
        #8000;
        bad_count = bad_count + 1;
        stop_test;
    end
endmodule
